/* File: shared/ccu_pkg.sv */
// Constants, types and helpers shared by the calendar clock unit files.
// Assumes a single 125 MHz clock and a CPU that drives one-cycle strobes.
package ccu_pkg;

  // Configuration register bit positions
  localparam int CFG_EN_BIT = 7;
  localparam int CFG_WREN_BIT = 5;
  localparam int CFG_SYNC_BIT = 4;
  localparam int CFG_HALF_BIT = 3;
  localparam int CFG_PTR_LSB = 0;
  localparam int CFG_PTR_MSB = 1;

  // Value window pointer codes
  localparam logic [1:0] PTR_MINUTES_SECONDS_PAIR = 2'h0;
  localparam logic [1:0] PTR_WDAY_HOUR = 2'h1;
  localparam logic [1:0] PTR_MONTH_DAY = 2'h2;
  localparam logic [1:0] PTR_YEAR = 2'h3;

  // Unlock key bytes
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;

  // Field limits, binary coded; year counts from 2000
  localparam logic [5:0] SEC_MAX = 6'h3B;
  localparam logic [5:0] MIN_MAX = 6'h3B;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [2:0] WDAY_MAX = 3'h6;
  localparam logic [3:0] MONTH_MAX = 4'hC;
  localparam logic [6:0] YEAR_MAX = 7'h63;
  localparam logic [3:0] MONTH_FEB = 4'h2;
  localparam logic [4:0] DAYS_31 = 5'h1F;
  localparam logic [4:0] DAYS_30 = 5'h1E;
  localparam logic [4:0] DAYS_29 = 5'h1D;
  localparam logic [4:0] DAYS_28 = 5'h1C;
  localparam logic [4:0] DAY_FIRST = 5'h01;
  localparam logic [3:0] MONTH_FIRST = 4'h1;

  // Time of day and calendar, travels as one word
  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [2:0] wday;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } ccu_time_t;

  localparam ccu_time_t TIME_RESET = '{year: '0, month: MONTH_FIRST, day: DAY_FIRST,
                                       wday: '0, hour: '0, min: '0, sec: '0};

  // Leap test is valid only inside 2000-2099, where divisible by four suffices
  function automatic logic is_leap(input logic [6:0] year);
    return (year[1:0] == 2'h0);
  endfunction

  // Last day of the given month
  function automatic logic [4:0] days_in_month(input logic [3:0] month,
                                               input logic [6:0] year);
    logic [4:0] d;
    d = DAYS_31;
    case (month)
      4'h4, 4'h6, 4'h9, 4'hB: d = DAYS_30;
      MONTH_FEB: d = is_leap(year) ? DAYS_29 : DAYS_28;
      default: d = DAYS_31;
    endcase
    return d;
  endfunction

endpackage

/* File: core/ccu_prescaler.sv */
// Two-stage prescaler producing a half-second tick for the calendar unit.
// Assumes clear_in and run_in come from logic on the same clock.
`timescale 1ns/10ps
module ccu_prescaler #(
  parameter int DIV1 = 125000,
  parameter int DIV2 = 500
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic clear_in,
  output logic half_tick_out,
  output logic last_slot_out
);
  import ccu_pkg::*;
  localparam int W1 = $clog2(DIV1);
  localparam int W2 = $clog2(DIV2);
  logic [W1-1:0] pre1_ff;
  logic [W2-1:0] pre2_ff;
  logic pre1_end;
  logic pre2_end;

  assign pre1_end = (pre1_ff == W1'(DIV1 - 1));
  assign pre2_end = (pre2_ff == W2'(DIV2 - 1));
  // Tick is suppressed when a clear lands, so phase restarts cleanly
  assign half_tick_out = run_in & ~clear_in & pre1_end & pre2_end;
  assign last_slot_out = pre2_end;

  // First stage, counts clock cycles
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pre1_ff <= '0;
    end else if (clear_in) begin
      pre1_ff <= '0;
    end else if (run_in) begin
      pre1_ff <= pre1_end ? '0 : pre1_ff + W1'(1);
    end
  end

  // Second stage, counts first-stage wraps
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pre2_ff <= '0;
    end else if (clear_in) begin
      pre2_ff <= '0;
    end else if (run_in && pre1_end) begin
      pre2_ff <= pre2_end ? '0 : pre2_ff + W2'(1);
    end
  end

  property p_presc_clear;
    @(posedge clk_in) disable iff (!rst_n_in)
    clear_in |=> (pre1_ff == '0) && (pre2_ff == '0) && !half_tick_out;
  endproperty
  a_presc_clear: assert property (p_presc_clear)
    else $error("prescalers not cleared");
endmodule

/* File: core/ccu_unlock.sv */
// Unlock sequence detector: key1 then key2 opens a short write-enable window.
// Assumes the CPU issues one write strobe per unlock-register store.
`timescale 1ns/10ps
module ccu_unlock #(
  parameter int WIN_CYCLES = 4
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wr_in,
  input wire logic [7:0] data_in,
  output logic open_out
);
  import ccu_pkg::*;
  localparam int WW = $clog2(WIN_CYCLES + 1);
  logic armed_ff;
  logic [WW-1:0] win_ff;

  // Any other store breaks the sequence, so stray writes cannot half-arm it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      armed_ff <= 1'b0;
    end else if (wr_in) begin
      armed_ff <= (data_in == UNLOCK_KEY1);
    end
  end

  // Window counts down after key2; a fresh store closes it early
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      win_ff <= '0;
    end else if (wr_in) begin
      win_ff <= (armed_ff && data_in == UNLOCK_KEY2) ? WW'(WIN_CYCLES) : '0;
    end else if (win_ff != '0) begin
      win_ff <= win_ff - WW'(1);
    end
  end

  assign open_out = (win_ff != '0);

  property p_unlock_open;
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_in && armed_ff && data_in == UNLOCK_KEY2) |=> open_out;
  endproperty
  a_unlock_open: assert property (p_unlock_open)
    else $error("window did not open after key sequence");

  property p_unlock_closed;
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_in && !armed_ff) |=> !open_out;
  endproperty
  a_unlock_closed: assert property (p_unlock_closed)
    else $error("window opened without key1");
endmodule

/* File: core/ccu_top.sv */
// Calendar clock unit: time counters, value window, write lock and status.
// Assumes CPU strobes are one-cycle pulses synchronous to SYS_CLK_IN.
`timescale 1ns/10ps
module ccu_top #(
  parameter int PRE1_DIV = 125000,
  parameter int PRE2_DIV = 500,
  parameter int UNLOCK_WIN = 4
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CFG_WR_IN,
  input wire logic [7:0] CFG_WDATA_IN,
  input wire logic UNLOCK_WR_IN,
  input wire logic [7:0] UNLOCK_WDATA_IN,
  input wire logic VALH_WR_IN,
  input wire logic VALH_RD_IN,
  input wire logic VALL_WR_IN,
  input wire logic VALL_RD_IN,
  input wire logic [7:0] VAL_WDATA_IN,
  output logic [7:0] CFG_RDATA_OUT,
  output logic [7:0] VALH_RDATA_OUT,
  output logic [7:0] VALL_RDATA_OUT,
  output ccu_pkg::ccu_time_t TIME_OUT,
  output logic SEC_PULSE_OUT
);
  import ccu_pkg::*;

  logic en_ff;
  logic wren_ff;
  logic half_ff;
  logic [1:0] ptr_ff;
  ccu_time_t time_ff;
  ccu_time_t nxt_time;
  logic [7:0] cfg_rd_ff;
  logic [7:0] valh_rd_ff;
  logic [7:0] vall_rd_ff;
  logic sec_pulse_ff;
  logic unlock_open;
  logic half_tick;
  logic last_slot;
  logic sec_tick;
  logic wr_hi;
  logic wr_lo;
  logic minutes_seconds_pair_wr;
  logic sync_bit;
  logic valh_access;
  logic day_adv;

  // Gated write strobes; without write enable nothing reaches the counters
  assign wr_hi = VALH_WR_IN & wren_ff;
  assign wr_lo = VALL_WR_IN & wren_ff;
  assign minutes_seconds_pair_wr = (wr_hi | wr_lo) & (ptr_ff == PTR_MINUTES_SECONDS_PAIR);
  assign valh_access = VALH_WR_IN | VALH_RD_IN;
  assign sec_tick = half_tick & half_ff;

  ccu_prescaler #(
    .DIV1(PRE1_DIV),
    .DIV2(PRE2_DIV)
  ) u_presc (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .run_in(en_ff),
    .clear_in(minutes_seconds_pair_wr),
    .half_tick_out(half_tick),
    .last_slot_out(last_slot)
  );

  ccu_unlock #(
    .WIN_CYCLES(UNLOCK_WIN)
  ) u_unlock (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .wr_in(UNLOCK_WR_IN),
    .data_in(UNLOCK_WDATA_IN),
    .open_out(unlock_open)
  );

  // Sync is high only during the last slot before a second rollover
  assign sync_bit = en_ff & half_ff & last_slot;

  // Module enable, software owned
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      en_ff <= 1'b0;
    end else if (CFG_WR_IN) begin
      en_ff <= CFG_WDATA_IN[CFG_EN_BIT];
    end
  end

  // Write enable: clearing always works, setting only inside the window
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      wren_ff <= 1'b0;
    end else if (CFG_WR_IN) begin
      wren_ff <= CFG_WDATA_IN[CFG_WREN_BIT] & (wren_ff | unlock_open);
    end
  end

  // Pointer: a config write wins over a same-cycle high-byte access
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      ptr_ff <= PTR_MINUTES_SECONDS_PAIR;
    end else if (CFG_WR_IN) begin
      ptr_ff <= CFG_WDATA_IN[CFG_PTR_MSB:CFG_PTR_LSB];
    end else if (valh_access && ptr_ff != PTR_MINUTES_SECONDS_PAIR) begin
      ptr_ff <= ptr_ff - 2'h1;
    end
  end

  // Half-second phase; only a seconds-byte write clears it
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      half_ff <= 1'b0;
    end else if (wr_lo && ptr_ff == PTR_MINUTES_SECONDS_PAIR) begin
      half_ff <= 1'b0;
    end else if (half_tick) begin
      half_ff <= ~half_ff;
    end
  end

  // Day rollover happens only when every finer field wraps together
  assign day_adv = sec_tick && time_ff.sec >= SEC_MAX && time_ff.min >= MIN_MAX &&
                   time_ff.hour >= HOUR_MAX;

  // Counting cascade, then software writes override the touched fields.
  // Count keeps running during writes except to the minutes/seconds pair, which restart the prescaler; a collision favours the write.
  always_comb begin
    nxt_time = time_ff;
    if (sec_tick) begin
      nxt_time.sec = time_ff.sec + 6'h1;
      if (time_ff.sec >= SEC_MAX) begin
        nxt_time.sec = '0;
        nxt_time.min = time_ff.min + 6'h1;
        if (time_ff.min >= MIN_MAX) begin
          nxt_time.min = '0;
          nxt_time.hour = time_ff.hour + 5'h1;
          if (time_ff.hour >= HOUR_MAX) begin
            nxt_time.hour = '0;
            nxt_time.wday = (time_ff.wday >= WDAY_MAX) ? '0 : time_ff.wday + 3'h1;
            nxt_time.day = time_ff.day + 5'h1;
            if (time_ff.day >= days_in_month(time_ff.month, time_ff.year)) begin
              nxt_time.day = DAY_FIRST;
              nxt_time.month = time_ff.month + 4'h1;
              if (time_ff.month >= MONTH_MAX) begin
                nxt_time.month = MONTH_FIRST;
                nxt_time.year = (time_ff.year >= YEAR_MAX) ? '0 : time_ff.year + 7'h1;
              end
            end
          end
        end
      end
    end
    // Writes land in this same edge, counting resumes from them
    if (wr_hi) begin
      case (ptr_ff)
        PTR_MINUTES_SECONDS_PAIR: nxt_time.min = VAL_WDATA_IN[5:0];
        PTR_WDAY_HOUR: nxt_time.wday = VAL_WDATA_IN[2:0];
        PTR_MONTH_DAY: nxt_time.month = VAL_WDATA_IN[3:0];
        default: nxt_time = nxt_time;
      endcase
    end
    if (wr_lo) begin
      case (ptr_ff)
        PTR_MINUTES_SECONDS_PAIR: nxt_time.sec = VAL_WDATA_IN[5:0];
        PTR_WDAY_HOUR: nxt_time.hour = VAL_WDATA_IN[4:0];
        PTR_MONTH_DAY: nxt_time.day = VAL_WDATA_IN[4:0];
        default: nxt_time.year = VAL_WDATA_IN[6:0];
      endcase
    end
  end

  // Time state
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      time_ff <= TIME_RESET;
    end else begin
      time_ff <= nxt_time;
    end
  end

  // Byte pair visible through the value window for a pointer value
  function automatic logic [15:0] window_pair(input logic [1:0] ptr, input ccu_time_t t);
    logic [15:0] v;
    v = '0;
    case (ptr)
      PTR_MINUTES_SECONDS_PAIR: v = {2'h0, t.min, 2'h0, t.sec};
      PTR_WDAY_HOUR: v = {5'h00, t.wday, 3'h0, t.hour};
      PTR_MONTH_DAY: v = {4'h0, t.month, 3'h0, t.day};
      default: v = {8'h00, 1'b0, t.year};
    endcase
    return v;
  endfunction

  // Read data registers; snapshot each cycle, so values lag state by one edge
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      cfg_rd_ff <= '0;
      valh_rd_ff <= '0;
      vall_rd_ff <= '0;
    end else begin
      cfg_rd_ff <= '0;
      cfg_rd_ff[CFG_EN_BIT] <= en_ff;
      cfg_rd_ff[CFG_WREN_BIT] <= wren_ff;
      cfg_rd_ff[CFG_SYNC_BIT] <= sync_bit;
      cfg_rd_ff[CFG_HALF_BIT] <= half_ff;
      cfg_rd_ff[CFG_PTR_MSB:CFG_PTR_LSB] <= ptr_ff;
      {valh_rd_ff, vall_rd_ff} <= window_pair(ptr_ff, time_ff);
    end
  end

  // Seconds pulse, lets software schedule writes right after a carry
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      sec_pulse_ff <= 1'b0;
    end else begin
      sec_pulse_ff <= sec_tick;
    end
  end

  assign CFG_RDATA_OUT = cfg_rd_ff;
  assign VALH_RDATA_OUT = valh_rd_ff;
  assign VALL_RDATA_OUT = vall_rd_ff;
  assign TIME_OUT = time_ff;
  assign SEC_PULSE_OUT = sec_pulse_ff;

  // Checks
  property p_ptr_dec;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (valh_access && !CFG_WR_IN && ptr_ff != PTR_MINUTES_SECONDS_PAIR) |=> ptr_ff == $past(ptr_ff) - 2'h1;
  endproperty
  a_ptr_dec: assert property (p_ptr_dec)
    else $error("pointer did not decrement");

  property p_ptr_hold;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (ptr_ff == PTR_MINUTES_SECONDS_PAIR && !CFG_WR_IN) |=> ptr_ff == PTR_MINUTES_SECONDS_PAIR;
  endproperty
  a_ptr_hold: assert property (p_ptr_hold)
    else $error("pointer left 00 without config write");

  property p_wr_ignored;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (!wren_ff && !sec_tick) |=> time_ff == $past(time_ff);
  endproperty
  a_wr_ignored: assert property (p_wr_ignored)
    else $error("time changed while writes locked");

  property p_wr_now;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (wr_lo && ptr_ff == PTR_MINUTES_SECONDS_PAIR) |=> time_ff.sec == $past(VAL_WDATA_IN[5:0]) && !half_ff;
  endproperty
  a_wr_now: assert property (p_wr_now)
    else $error("seconds write not applied at once");

  property p_stopped;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (!en_ff [*2]) |-> !sec_tick && !SEC_PULSE_OUT;
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("count advanced while disabled");

  property p_leap_feb;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (day_adv && !wr_lo && !wr_hi && time_ff.month == MONTH_FEB && time_ff.day == DAYS_28)
      |=> (time_ff.day == DAYS_29) == is_leap($past(time_ff.year));
  endproperty
  a_leap_feb: assert property (p_leap_feb)
    else $error("February length wrong for year");

  property p_month_roll;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (day_adv && !wr_lo && !wr_hi && time_ff.month == 4'h4 && time_ff.day == DAYS_30)
      |=> time_ff.day == DAY_FIRST && time_ff.month == 4'h5;
  endproperty
  a_month_roll: assert property (p_month_roll)
    else $error("30-day month did not roll");

  property p_sync_safe;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    sec_tick |-> $past(sync_bit) || $past(CFG_WR_IN) || $past(minutes_seconds_pair_wr);
  endproperty
  a_sync_safe: assert property (p_sync_safe)
    else $error("rollover outside the flagged window");

  property p_wren_lock;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (CFG_WR_IN && !unlock_open && !wren_ff) |=> !wren_ff;
  endproperty
  a_wren_lock: assert property (p_wren_lock)
    else $error("write enable set outside unlock window");

  // Clearing the write enable must always work, open window or not
  property p_wren_clear;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (CFG_WR_IN && !CFG_WDATA_IN[CFG_WREN_BIT]) |=> !wren_ff;
  endproperty
  a_wren_clear: assert property (p_wren_clear)
    else $error("write enable not cleared by config write");

  // Half-second bit is read-only: only the tick or a seconds write moves it
  property p_half_ro;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (!half_tick && !(wr_lo && ptr_ff == PTR_MINUTES_SECONDS_PAIR)) |=> half_ff == $past(half_ff);
  endproperty
  a_half_ro: assert property (p_half_ro)
    else $error("half-second changed without tick or seconds write");

  // Every seconds increment shows up on the pulse one edge later
  property p_sec_pulse;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    sec_tick |=> SEC_PULSE_OUT;
  endproperty
  a_sec_pulse: assert property (p_sec_pulse)
    else $error("seconds pulse missing after increment");

  // Last second of the last year wraps the calendar back to its start
  property p_year_wrap;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (day_adv && !wr_lo && !wr_hi && time_ff.month == MONTH_MAX && time_ff.day == DAYS_31 &&
     time_ff.year == YEAR_MAX) |=> time_ff.year == '0 && time_ff.month == MONTH_FIRST;
  endproperty
  a_year_wrap: assert property (p_year_wrap)
    else $error("year did not wrap after the last year");
endmodule

/* File: tb/ccu_tb.sv */
// Self-checking bench for the calendar clock unit top level.
// Assumes short prescaler counts, so one second lasts 16 clocks.
`timescale 1ns/10ps
module tb;
  import ccu_pkg::*;
  typedef struct packed {
    logic [2:0] kind;
    logic [7:0] exp;
    logic [7:0] msk;
    ccu_time_t tm;
  } ccu_note_t;
  localparam int P1 = 4;
  localparam int P2 = 2;
  localparam int S_CFG = 0;
  localparam int S_UN = 1;
  localparam int S_HW = 2;
  localparam int S_HR = 3;
  localparam int S_LW = 4;
  localparam int S_LR = 5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] stb = 6'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] cfg_q, vh_q, vl_q;
  logic [7:0] cnt_q = 8'h00;
  ccu_time_t time_q;
  logic pulse;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] rng = 32'h0000_0061;
  ccu_note_t q[$];
  ccu_note_t n;
  event smp;

  ccu_top #(.PRE1_DIV(P1), .PRE2_DIV(P2), .UNLOCK_WIN(4)) uut (
    .SYS_CLK_IN(clk), .RST_N_IN(rst_n),
    .CFG_WR_IN(stb[S_CFG]), .CFG_WDATA_IN(wd),
    .UNLOCK_WR_IN(stb[S_UN]), .UNLOCK_WDATA_IN(wd),
    .VALH_WR_IN(stb[S_HW]), .VALH_RD_IN(stb[S_HR]),
    .VALL_WR_IN(stb[S_LW]), .VALL_RD_IN(stb[S_LR]), .VAL_WDATA_IN(wd),
    .CFG_RDATA_OUT(cfg_q), .VALH_RDATA_OUT(vh_q), .VALL_RDATA_OUT(vl_q),
    .TIME_OUT(time_q), .SEC_PULSE_OUT(pulse)
  );

  // Free-running clock, 8 ns period
  always #4 clk = ~clk;

  // Hang guard, generous over the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors++;
      $display("mismatch t=%0t timeout", $time);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Own month length table, kept apart from the design's helpers
  function automatic logic [4:0] mdays(input logic [3:0] m, input logic [6:0] y);
    if (m == 4'h2)
      return (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
    if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hB)
      return 5'h1E;
    return 5'h1F;
  endfunction

  function automatic logic [15:0] pair(input ccu_time_t t, input int p);
    case (p)
      3: return {9'h000, t.year};
      2: return {4'h0, t.month, 3'h0, t.day};
      1: return {5'h00, t.wday, 3'h0, t.hour};
      default: return {2'h0, t.min, 2'h0, t.sec};
    endcase
  endfunction

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e, input logic [7:0] m);
    checked++;
    if ((g & m) !== (e & m)) begin
      errors++;
      $display("mismatch t=%0t byte got %h exp %h", $time, g & m, e & m);
    end
  endtask

  task automatic cmp_t(input ccu_time_t g, input ccu_time_t e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch t=%0t time got %h exp %h", $time, g, e);
    end
  endtask

  // Watcher: each sample request drains every queued note, oldest first
  always begin
    @smp;
    while (q.size() > 0) begin
      n = q.pop_front();
      case (n.kind)
        3'h0: cmp8(cfg_q, n.exp, n.msk);
        3'h1: cmp8(vh_q, n.exp, n.msk);
        3'h2: cmp8(vl_q, n.exp, n.msk);
        3'h3: cmp_t(time_q, n.tm);
        default: cmp8(cnt_q, n.exp, n.msk);
      endcase
    end
  end

  task automatic note(input logic [2:0] k, input logic [7:0] e, input logic [7:0] m,
                      input ccu_time_t t);
    q.push_back('{k, e, m, t});
    -> smp;
  endtask

  // One-cycle strobe; data shared by all write ports
  task automatic strobe(input int which, input logic [7:0] d);
    @(posedge clk);
    stb[which] <= 1'b1;
    wd <= d;
    @(posedge clk);
    stb <= 6'h00;
  endtask

  // Registered views need one more edge
  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  task automatic wait_pulse(output int c);
    c = 0;
    do begin
      settle();
      c++;
    end while (pulse !== 1'b1 && c < 60);
  endtask

  // Pointer starts at 3 and walks down with every high-byte write
  task automatic set_time(input logic en, input ccu_time_t t);
    strobe(S_CFG, {en, 7'h23});
    strobe(S_LW, {1'b0, t.year});
    strobe(S_HW, 8'h00);
    strobe(S_LW, {3'h0, t.day});
    strobe(S_HW, {4'h0, t.month});
    strobe(S_LW, {3'h0, t.hour});
    strobe(S_HW, {5'h00, t.wday});
    strobe(S_LW, {2'h0, t.sec});
    strobe(S_HW, {2'h0, t.min});
  endtask

  initial begin
    ccu_time_t t, e;
    logic [3:0] m;
    logic [6:0] y;
    logic [4:0] d;
    int c;
    logic [15:0] pv;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    note(3'h3, 8'h00, 8'h00, TIME_RESET);
    note(3'h0, 8'h00, 8'hFF, TIME_RESET);
    // Locked writes and bad unlock attempts
    strobe(S_LW, 8'h05);
    settle();
    note(3'h3, 8'h00, 8'h00, TIME_RESET); // locked
    strobe(S_UN, UNLOCK_KEY1);
    strobe(S_UN, 8'h00);
    strobe(S_UN, UNLOCK_KEY2);
    strobe(S_CFG, 8'h20);
    settle();
    note(3'h0, 8'h00, 8'h20, TIME_RESET); // broken keys
    strobe(S_UN, UNLOCK_KEY1);
    strobe(S_UN, UNLOCK_KEY2);
    repeat (6) @(posedge clk);
    strobe(S_CFG, 8'h20);
    settle();
    note(3'h0, 8'h00, 8'h20, TIME_RESET); // too late
    strobe(S_UN, UNLOCK_KEY1); // nothing between keys
    strobe(S_UN, UNLOCK_KEY2);
    strobe(S_CFG, 8'h23);
    settle();
    note(3'h0, 8'h23, 8'hE7, TIME_RESET); // opened
    // Random fields written, then read back through the window
    for (int r = 0; r < 2; r++) begin
      t = '{year: 7'(xs() % 100), month: 4'(xs() % 12 + 1), day: 5'(xs() % 28 + 1),
            wday: 3'(xs() % 7), hour: 5'(xs() % 24), min: 6'(xs() % 60),
            sec: 6'(xs() % 60)};
      set_time(1'b0, t);
      settle();
      note(3'h3, 8'h00, 8'h00, t); // stored
      strobe(S_CFG, 8'h23);
      for (int p = 3; p >= 0; p--) begin
        settle();
        pv = pair(t, p);
        note(3'h2, pv[7:0], 8'hFF, t); // low
        note(3'h1, pv[15:8], 8'hFF, t); // high
        note(3'h0, 8'(p), 8'h03, t); // pointer
        settle();
        note(3'h2, pv[7:0], 8'hFF, t); // read twice
        strobe(S_LR, 8'h00);
        strobe(S_HR, 8'h00);
      end
      settle();
      note(3'h0, 8'h00, 8'h03, t); // parked at zero
    end
    // Day, month and year carries from the last second of each month, and of 28 February in a leap year
    for (int i = 0; i < 15; i++) begin
      m = (i < 12) ? 4'(i + 1) : 4'h2;
      y = (m == 4'hC) ? 7'h63 : (i == 12 || i == 14) ? 7'h04 : (i == 13) ? 7'h00 : 7'h01;
      d = mdays(m, y) - ((i == 14) ? 5'h01 : 5'h00);
      t = '{year: y, month: m, day: d, wday: 3'h6, hour: 5'h17, min: 6'h3B, sec: 6'h3B};
      e = '{year: y, month: m, day: d + 5'h01, wday: 3'h0, hour: 5'h00, min: 6'h00,
            sec: 6'h00};
      if (d == mdays(m, y)) begin
        e.day = 5'h01;
        e.month = (m == 4'hC) ? 4'h1 : m + 4'h1;
        if (m == 4'hC)
          e.year = (y == 7'h63) ? 7'h00 : y + 7'h01;
      end
      set_time(1'b0, t);
      strobe(S_CFG, 8'hA0);
      wait_pulse(c);
      note(3'h3, 8'h00, 8'h00, e); // rollover
      strobe(S_CFG, 8'h20);
    end
    repeat (40) @(posedge clk);
    settle();
    note(3'h3, 8'h00, 8'h00, e); // halted
    // Running count: spacing, status bits and a resync write
    t = '{year: 7'h05, month: 4'h3, day: 5'h0A, wday: 3'h2, hour: 5'h08, min: 6'h00,
          sec: 6'h00};
    set_time(1'b1, t);
    wait_pulse(c);
    wait_pulse(c);
    cnt_q = 8'(c);
    note(3'h4, 8'(2 * P1 * P2), 8'hFF, t); // one second
    t.sec = 6'h02;
    note(3'h3, 8'h00, 8'h00, t); // counted on
    settle();
    note(3'h0, 8'h00, 8'h10, t); // safe early
    repeat (8) settle();
    note(3'h0, 8'h08, 8'h08, t); // half visible
    repeat (4) settle();
    note(3'h0, 8'h10, 8'h10, t); // unsafe late
    wait_pulse(c);
    repeat (9) settle();
    strobe(S_LW, 8'h1E); // well clear of an increment
    settle();
    note(3'h0, 8'h00, 8'h08, t); // half cleared
    t.sec = 6'h1E;
    note(3'h3, 8'h00, 8'h00, t); // same cycle
    wait_pulse(c);
    cnt_q = {7'h00, (c >= 13 && c <= 18)};
    note(3'h4, 8'h01, 8'hFF, t); // phase reset
    t.sec = 6'h1F;
    note(3'h3, 8'h00, 8'h00, t); // resumed
    // Leave the write lock closed
    strobe(S_CFG, 8'h00);
    settle();
    note(3'h0, 8'h00, 8'hA0, t); // cleared
    settle();
    tally_and_finish();
  end
endmodule
